// ### hw/pavi_host_ctrl.sv
// Purpose: host sequencer that initializes the interrupt controller and runs acknowledges
// Assumes: APB slave with zero wait states; controller wired to the pin ports
// Notes:   one job at a time; start bits written while busy are dropped
//
// The APB register port and the placing of the registers are this design's own decisions.
`default_nettype none

module pavi_host_ctrl
  import pavi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // controller pins
  output logic             picSelN,
  output logic             picWrN,
  output logic             picRdN,
  output logic             addressLine,
  output logic      [7:0]  picDataOut,
  output logic             picDataOe,
  input  wire logic [7:0]  picDataIn,
  output logic             intrAckStrobeN,
  input  wire logic        picIntIn
);

  typedef struct packed {
    pavi_state_e st;
    logic [3:0]  cnt;
    logic [2:0]  step;
    logic [1:0]  pulse;
    logic [7:0]  init1;
    logic [7:0]  init2;
    logic [7:0]  casc;
    logic [7:0]  init4;
    logic [8:0]  opCmd;
    logic        initDone;
    logic        callOk;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
    logic [2:0]  level;
    logic        selN;
    logic        wrN;
    logic        addr;
    logic [7:0]  dout;
    logic        oe;
    logic        ackN;
    logic [31:0] rdata;
    logic        slverr;
  } pavi_host_s;

  pavi_host_s h_q;
  pavi_host_s h_d;
  logic [8:0] pinSync;
  logic       wordFmt;
  logic [1:0] lastPulse;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // next init step: cascade word only when not single, fourth only when asked
  function automatic logic [2:0] nextStep(input logic [2:0] s, input logic [7:0] w1);
    logic [2:0] n;
    n = STEP_DONE;
    unique case (s)
      STEP_W1:   n = STEP_W2;
      STEP_W2:   n = !w1[W1_SINGLE_BIT] ? STEP_CASC :
                     (w1[W1_FOURTH_BIT] ? STEP_W4 : STEP_DONE);
      STEP_CASC: n = w1[W1_FOURTH_BIT] ? STEP_W4 : STEP_DONE;
      default:   n = STEP_DONE;
    endcase
    return n;
  endfunction

  // byte placed on the data bus and address-line level for a write step
  function automatic logic [8:0] stepWord(input pavi_host_s q, input logic [2:0] s);
    logic [8:0] w;
    w = {1'b1, q.init2};
    unique case (s)
      STEP_W1:   w = {1'b0, q.init1 | (8'h01 << W1_MARK_BIT)};
      STEP_W2:   w = {1'b1, q.init2};
      STEP_CASC: w = {1'b1, q.casc};
      STEP_W4:   w = {1'b1, q.init4};
      default:   w = q.opCmd;
    endcase
    return w;
  endfunction

  // request level out of the address-carrying byte
  function automatic logic [2:0] reqLevel(input logic [7:0] b, input logic wf,
                                          input logic intvl4);
    logic [2:0] l;
    if (wf) begin
      l = b[2:0];
    end else if (intvl4) begin
      l = b[4:2];
    end else begin
      l = b[5:3];
    end
    return l;
  endfunction

  // ****************************************************************
  // pin inputs
  // ****************************************************************
  pavi_pin_sync #(
    .WIDTH (9)
  ) u_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pinIn     ({picIntIn, picDataIn}),
    .pinStable (pinSync)
  );

  // without a fourth word the controller runs the byte format
  assign wordFmt   = h_q.init1[W1_FOURTH_BIT] & h_q.init4[W4_FORMAT_BIT];
  assign lastPulse = wordFmt ? 2'd1 : 2'd2;

  // ****************************************************************
  // register file and sequencer
  // ****************************************************************
  always_comb begin
    logic       wrAcc;
    logic       rdAcc;
    logic [8:0] w;
    h_d    = h_q;
    wrAcc  = psel & penable & pwrite;
    rdAcc  = psel & ~penable & ~pwrite;
    w      = stepWord(h_q, h_q.step);
    // register reads; decode in setup so read data comes from a flop
    if (rdAcc) begin
      h_d.slverr = 1'b0;
      h_d.rdata  = '0;
      unique case (paddr)
        OFS_CTRL:   h_d.rdata[3:0] = {pinSync[8], h_q.callOk, h_q.initDone,
                                      h_q.st != ST_IDLE};
        OFS_INIT1:  h_d.rdata[7:0] = h_q.init1;
        OFS_INIT2:  h_d.rdata[7:0] = h_q.init2;
        OFS_CASC:   h_d.rdata[7:0] = h_q.casc;
        OFS_INIT4:  h_d.rdata[7:0] = h_q.init4;
        OFS_OPCMD:  h_d.rdata[8:0] = h_q.opCmd;
        OFS_RESULT: h_d.rdata[26:0] = {h_q.level, h_q.byte3, h_q.byte2, h_q.byte1};
        default:    h_d.slverr = 1'b1;
      endcase
    end else if (psel & ~penable & pwrite) begin
      h_d.slverr = !(paddr inside {OFS_CTRL, OFS_INIT1, OFS_INIT2, OFS_CASC,
                                   OFS_INIT4, OFS_OPCMD});
    end
    if (wrAcc && h_q.st == ST_IDLE) begin
      unique case (paddr)
        OFS_INIT1: h_d.init1 = pwdata[7:0];
        OFS_INIT2: h_d.init2 = pwdata[7:0];
        OFS_CASC:  h_d.casc  = pwdata[7:0];
        OFS_INIT4: h_d.init4 = pwdata[7:0];
        OFS_OPCMD: h_d.opCmd = pwdata[8:0];
        OFS_CTRL: begin
          if (pwdata[CTRL_INIT_BIT]) begin
            // a new first word restarts the whole sequence
            h_d.initDone = 1'b0;
            h_d.step     = STEP_W1;
            h_d.st       = ST_WSETUP;
          end else if (pwdata[CTRL_ACK_BIT] && h_q.initDone) begin
            h_d.pulse = 2'd0;
            h_d.cnt   = STROBE_CYC;
            h_d.ackN  = 1'b0;
            h_d.st    = ST_ALOW;
          end else if (pwdata[CTRL_OPCMD_BIT] && h_q.initDone) begin
            h_d.step = STEP_OPCMD;
            h_d.st   = ST_WSETUP;
          end
        end
        default: ;
      endcase
    end
    // pin sequencing
    unique case (h_q.st)
      ST_IDLE: begin
        h_d.selN = 1'b1;
        h_d.oe   = 1'b0;
      end
      // address, data and select are driven on the same edge as the strobe falls
      ST_WSETUP: begin
        h_d.selN = 1'b0;
        h_d.addr = w[8];
        h_d.dout = w[7:0];
        h_d.oe   = 1'b1;
        h_d.wrN  = 1'b0;
        h_d.cnt  = STROBE_CYC;
        h_d.st   = ST_WLOW;
      end
      ST_WLOW: begin
        if (h_q.cnt == 4'd1) begin
          h_d.wrN = 1'b1;
          h_d.cnt = RECOV_CYC;
          h_d.st  = ST_WREC;
        end else begin
          h_d.cnt = h_q.cnt - 4'd1;
        end
      end
      // data held through the rising strobe edge, then released
      ST_WREC: begin
        h_d.selN = 1'b1;
        h_d.oe   = 1'b0;
        if (h_q.cnt == 4'd1) begin
          if (h_q.step == STEP_OPCMD || nextStep(h_q.step, h_q.init1) == STEP_DONE) begin
            h_d.initDone = h_q.initDone | (h_q.step != STEP_OPCMD);
            h_d.st       = ST_IDLE;
          end else begin
            h_d.step = nextStep(h_q.step, h_q.init1);
            h_d.st   = ST_WSETUP;
          end
        end else begin
          h_d.cnt = h_q.cnt - 4'd1;
        end
      end
      // the bus is sampled on the last low cycle of each acknowledge pulse
      ST_ALOW: begin
        if (h_q.cnt == 4'd1) begin
          h_d.ackN = 1'b1;
          h_d.cnt  = RECOV_CYC;
          h_d.st   = ST_AREC;
          unique case (h_q.pulse)
            2'd0: begin
              h_d.byte1  = wordFmt ? 8'h00 : pinSync[7:0];
              h_d.callOk = wordFmt | (pinSync[7:0] == CALL_CODE);
            end
            2'd1: begin
              h_d.byte2 = pinSync[7:0];
              h_d.level = reqLevel(pinSync[7:0], wordFmt,
                                   h_q.init1[W1_INTVL_BIT]);
            end
            default: h_d.byte3 = pinSync[7:0];
          endcase
        end else begin
          h_d.cnt = h_q.cnt - 4'd1;
        end
      end
      ST_AREC: begin
        if (h_q.cnt == 4'd1) begin
          if (h_q.pulse == lastPulse) begin
            h_d.st = ST_IDLE;
          end else begin
            h_d.pulse = h_q.pulse + 2'd1;
            h_d.ackN  = 1'b0;
            h_d.cnt   = STROBE_CYC;
            h_d.st    = ST_ALOW;
          end
        end else begin
          h_d.cnt = h_q.cnt - 4'd1;
        end
      end
      default: h_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_q       <= '0;
      h_q.st    <= ST_IDLE;
      h_q.init1 <= INIT1_RST;
      h_q.init2 <= INIT2_RST;
      h_q.casc  <= CASC_RST;
      h_q.init4 <= INIT4_RST;
      h_q.selN  <= 1'b1;
      h_q.wrN   <= 1'b1;
      h_q.ackN  <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // status reads are not issued; the read strobe stays inactive
  assign picRdN         = 1'b1;
  assign picSelN        = h_q.selN;
  assign picWrN         = h_q.wrN;
  assign addressLine    = h_q.addr;
  assign picDataOut     = h_q.dout;
  assign picDataOe      = h_q.oe;
  assign intrAckStrobeN = h_q.ackN;
  assign prdata         = h_q.rdata;
  assign pslverr        = h_q.slverr;
  assign pready         = 1'b1;

endmodule // pavi_host_ctrl

`default_nettype wire

// ### hw/pavi_pkg.sv
// Purpose: constants shared by the interrupt-controller host sequencer
// Assumes: 25 MHz clk, APB register port, controller reached through its pins
// Notes:   How the sequencer drives initialization and acknowledge cycles is listed below
`default_nettype none

package pavi_pkg;

  // ****************************************************************
  // register map of the host sequencer (APB, one word each)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INIT1  = 8'h04;
  localparam logic [7:0] OFS_INIT2  = 8'h08;
  localparam logic [7:0] OFS_CASC   = 8'h0C;
  localparam logic [7:0] OFS_INIT4  = 8'h10;
  localparam logic [7:0] OFS_OPCMD  = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;

  // control bits (write) and status bits (read) at OFS_CTRL; address-line bit of OFS_OPCMD
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_ACK_BIT  = 1;
  localparam int CTRL_OPCMD_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CALL_BIT = 2;
  localparam int STAT_INT_BIT  = 3;
  localparam int OPCMD_ADDR_BIT = 8;

  // ****************************************************************
  // init word field positions, reset values and the call code
  // ****************************************************************
  localparam int W1_FOURTH_BIT = 0;
  localparam int W1_SINGLE_BIT = 1;
  localparam int W1_INTVL_BIT  = 2;
  localparam int W1_LEVEL_BIT  = 3;
  localparam int W1_MARK_BIT   = 4;
  localparam int W4_FORMAT_BIT = 0;
  localparam logic [7:0] INIT1_RST = 8'h13;
  localparam logic [7:0] INIT2_RST = 8'h00;
  localparam logic [7:0] CASC_RST  = 8'h00;
  localparam logic [7:0] INIT4_RST = 8'h01;
  localparam logic [7:0] CALL_CODE = 8'hCD;

  // init step codes; step 4 is an operation command word
  localparam logic [2:0] STEP_W1   = 3'h0;
  localparam logic [2:0] STEP_W2   = 3'h1;
  localparam logic [2:0] STEP_CASC = 3'h2;
  localparam logic [2:0] STEP_W4   = 3'h3;
  localparam logic [2:0] STEP_OPCMD = 3'h4;
  localparam logic [2:0] STEP_DONE = 3'h7;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS    = 40;
  localparam int STROBE_NS = 200;  // least strobe low time
  localparam int RECOV_NS  = 160;  // least high time between strobes
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RECOV_CYC  = 4'((RECOV_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WSETUP = 3'b001,
    ST_WLOW   = 3'b010,
    ST_WREC   = 3'b011,
    ST_ALOW   = 3'b100,
    ST_AREC   = 3'b101
  } pavi_state_e;

endpackage : pavi_pkg

`default_nettype wire

// ### hw/pavi_pin_sync.sv
// Purpose: three-stage sampler for pins arriving from the controller
// Assumes: inputs asynchronous to clk
// Notes:   output moves only when stages two and three agree
`default_nettype none

module pavi_pin_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinStable
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } pavi_sync_s;

  pavi_sync_s sync_q;
  pavi_sync_s sync_d;

  // ****************************************************************
  // sampler
  // ****************************************************************
  // s1 feeds only s2, so metastability never reaches the compare
  always_comb begin
    sync_d    = sync_q;
    sync_d.s1 = pinIn;
    sync_d.s2 = sync_q.s1;
    sync_d.s3 = sync_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (sync_q.s2[i] == sync_q.s3[i]) begin
        sync_d.stable[i] = sync_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign pinStable = sync_q.stable;

endmodule // pavi_pin_sync

`default_nettype wire

// ### bench/pavi_dev_model.sv
// Purpose: behavioural interrupt controller facing the host sequencer
// Assumes: strobes are active-low levels driven by the host
// Notes:   a released bus shows the inverse of the last byte
`default_nettype none

module pavi_dev_model (
  input  wire logic       selN,
  input  wire logic       wrN,
  input  wire logic       addrLine,
  input  wire logic [7:0] din,
  input  wire logic       ackN,
  input  wire logic       pend,
  input  wire logic [2:0] reqLvl,
  output logic      [7:0] dout,
  output logic            intOut,
  output logic      [7:0] w1,
  output logic      [7:0] w2,
  output logic      [7:0] w4,
  output logic      [7:0] opWord,
  output logic      [7:0] words,
  output logic      [7:0] acks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step = 2'h3;  // 0 base, 1 cascade, 2 fourth, 3 done
  logic [1:0] idx  = 2'h0;
  logic [2:0] lvl  = 3'h7;
  logic       drv  = 1'b0;
  logic [7:0] val  = 8'h00;
  logic [7:0] casc = 8'h00;

  // ********
  // bus side
  // ********
  assign intOut = pend;
  assign dout   = drv ? val : ~val;  // a stale byte must never look valid
  initial begin
    {w1, w2, w4, opWord, words, acks} = '0;
  end

  // words are taken as the write strobe ends
  always @(posedge wrN) begin
    if (!selN && !addrLine && din[4]) begin
      w1    = din;
      step  = 2'h0;
      idx   = 2'h0;
      words = 8'h01;
      if (!din[0]) w4 = 8'h00;
    end else if (!selN) begin
      words = words + 8'(step != 2'h3);
      case (step)
        2'h0: begin
          w2   = din;
          step = !w1[1] ? 2'h1 : (w1[0] ? 2'h2 : 2'h3);
        end
        2'h1: begin
          casc = din;
          step = w1[0] ? 2'h2 : 2'h3;
        end
        2'h2: begin
          w4   = din;
          step = 2'h3;
        end
        default: opWord = din;
      endcase
    end
  end

  // acknowledge pulses; the level is frozen on the first one
  always @(negedge ackN) begin
    acks++;
    if (idx == 2'h0) lvl = pend ? reqLvl : 3'h7;
    if (w4[0]) begin
      drv = (idx == 2'h1);
      if (drv) val = {w2[7:3], lvl};
      idx = drv ? 2'h0 : 2'h1;
    end else begin
      drv = 1'b1;
      case (idx)
        2'h0:    val = 8'hCD;
        2'h1:    val = w1[2] ? {w1[7:5], lvl, 2'b00} : {w1[7:6], lvl, 3'b000};
        default: val = w2;
      endcase
      idx = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
    end
  end
  always @(posedge ackN) drv = 1'b0;
endmodule // pavi_dev_model
`default_nettype wire

// ### bench/pavi_host_ctrl_sva.sv
// Purpose: timing checks on the host sequencer's bus and pins
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound to every host sequencer instance
`default_nettype none

module pavi_host_ctrl_sva
  import pavi_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       picSelN,
  input wire logic       picWrN,
  input wire logic       addressLine,
  input wire logic [7:0] picDataOut,
  input wire logic       picDataOe,
  input wire logic       intrAckStrobeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ********
  // pin strobes
  // ********
  wr_pulse_len_a: assert property ($fell(picWrN) |-> (!picWrN)[*5] ##1 picWrN)
    else $error("write strobe width wrong");
  wr_qualified_a: assert property (!picWrN |-> !picSelN && picDataOe && intrAckStrobeN)
    else $error("write strobe without select or data");
  wr_data_hold_a: assert property (!picWrN && !$past(picWrN)
      |-> $stable(picDataOut) && $stable(addressLine))
    else $error("write data moved under strobe");
  sel_release_a: assert property ($rose(picWrN) |=> picSelN && !picDataOe)
    else $error("select held after strobe");
  word_gap_a: assert property ($rose(picSelN) |-> picSelN[*4])
    else $error("words too close");
  ack_pulse_len_a: assert property ($fell(intrAckStrobeN)
      |-> (!intrAckStrobeN)[*5] ##1 intrAckStrobeN[*4])
    else $error("acknowledge pulse shape wrong");
  ack_bus_free_a: assert property (!intrAckStrobeN |-> !picDataOe && picSelN)
    else $error("host drives bus during acknowledge");
  // unmapped or unaligned words, and writes to the result word, answer with an error
  unmapped_err_a: assert property (psel && penable
      |-> pslverr == !(paddr[1:0] == 2'b00 && paddr <= (pwrite ? OFS_OPCMD : OFS_RESULT)))
    else $error("slave error flag wrong");

  // main scenarios reached
  cover property ($fell(picWrN) && addressLine);
  cover property ($fell(intrAckStrobeN));
  cover property (psel && penable && pslverr);
endmodule // pavi_host_ctrl_sva

bind pavi_host_ctrl pavi_host_ctrl_sva u_sva (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pslverr(pslverr), .picSelN(picSelN), .picWrN(picWrN), .addressLine(addressLine),
  .picDataOut(picDataOut), .picDataOe(picDataOe), .intrAckStrobeN(intrAckStrobeN)
);
`default_nettype wire

// ### bench/tb.sv
// Purpose: self-checking bench for the host sequencer
// Assumes: 25 MHz clock, zero-wait APB slave
// Notes:   random words from a fixed seed, corner cases among them
`default_nettype none

module tb
  import pavi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, picSelN, picWrN, picRdN, addressLine, picDataOe;
  logic        intrAckStrobeN, picIntIn, pend = 1'b0;
  logic [7:0]  picDataOut, picDataIn, devOut, mW1, mW2, mW4, mOpWord, mWords, mAcks;
  logic [2:0]  reqLvl = 3'h0;
  int          err_count = 0, checks_done = 0;

  // ********
  // clock, wiring, instances
  // ********
  initial forever #20 clk = ~clk;
  assign picDataIn = picDataOe ? picDataOut : devOut;  // shared bus wire
  pavi_host_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .picSelN(picSelN), .picWrN(picWrN), .picRdN(picRdN),
    .addressLine(addressLine), .picDataOut(picDataOut), .picDataOe(picDataOe),
    .picDataIn(picDataIn), .intrAckStrobeN(intrAckStrobeN), .picIntIn(picIntIn));
  pavi_dev_model u_dev (.selN(picSelN), .wrN(picWrN), .addrLine(addressLine), .din(picDataOut),
    .ackN(intrAckStrobeN), .pend(pend), .reqLvl(reqLvl), .dout(devOut), .intOut(picIntIn),
    .w1(mW1), .w2(mW2), .w4(mW4), .opWord(mOpWord), .words(mWords), .acks(mAcks));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one APB transfer; the request stands until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll busy with a bounded count; r keeps the last status word
  task automatic wait_idle(output logic [31:0] r);
    logic e;
    int   n;
    n = 0;
    do begin
      apb(OFS_CTRL, 1'b0, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      err_count++;
      give_verdict();
    end
  endtask

  function automatic logic [31:0] exp_res(input logic [7:0] w1, w2, input logic wd,
                                          input logic [2:0] l);
    logic [7:0] b2;
    if (wd) return {5'h0, l, 8'h00, w2[7:3], l, 8'h00};
    b2 = w1[2] ? {w1[7:5], l, 2'b00} : {w1[7:6], l, 3'b000};
    return {5'h0, l, w2, b2, 8'hCD};
  endfunction

  // ********
  // main sequence
  // ********
  initial begin
    logic [31:0] r, res, msk;
    logic        e, wd;
    logic [7:0]  w1, w2, w4v, acks0, d, lo [4], ofs [5], rv [5];
    logic [3:0]  fm;
    logic [2:0]  lv, l;
    lo  = '{8'h12, 8'h16, 8'h11, 8'h1D};
    fm  = 4'b1011;  // fourth-word format bit per config, ignored without fourth word
    ofs = '{OFS_INIT1, OFS_INIT2, OFS_CASC, OFS_INIT4, OFS_OPCMD};
    rv  = '{INIT1_RST, INIT2_RST, CASC_RST, INIT4_RST, 8'h00};
    void'($urandom(32'hDF56CAFB));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ofs[k]) begin
      apb(ofs[k], 1'b0, 32'h0, r, e);
      chk(r, {24'h0, rv[k]}, "reset value");
    end
    apb(8'h1C, 1'b0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    apb(OFS_RESULT, 1'b1, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "read-only error");
    chk({31'h0, picRdN}, 32'h1, "read strobe idle");
    apb(OFS_CTRL, 1'b1, 32'h2, r, e);
    wait_idle(r);
    chk({24'h0, mAcks}, 32'h0, "ack before init");
    $display("test reset_and_refusal done");
    for (int i = 0; i < 4; i++) begin
      w1  = {3'($urandom), lo[i][4:0]};
      w2  = 8'($urandom);
      w4v = {7'($urandom), fm[i]};
      apb(OFS_INIT1, 1'b1, {24'h0, w1}, r, e);
      apb(OFS_INIT2, 1'b1, {24'h0, w2}, r, e);
      apb(OFS_CASC, 1'b1, 32'($urandom % 256), r, e);
      apb(OFS_INIT4, 1'b1, {24'h0, w4v}, r, e);
      apb(OFS_CTRL, 1'b1, 32'h1, r, e);
      wait_idle(r);
      chk({31'h0, r[STAT_DONE_BIT]}, 32'h1, "init done");
      chk({24'h0, mWords}, 32'(2 + !w1[1] + w1[0]), "init word count");
      chk({24'h0, mW1}, {24'h0, w1}, "first word");
      chk({24'h0, mW2}, {24'h0, w2}, "base word");
      chk({24'h0, mW4}, {24'h0, w1[0] ? w4v : 8'h00}, "fourth word");
      wd = w1[0] & w4v[0];
      // first pass has no request pending, so level 7 answers
      for (int j = 0; j < 3; j++) begin
        acks0 = mAcks;
        lv = 3'($urandom);
        l  = (j != 0) ? lv : 3'h7;
        pend   <= (j != 0);
        reqLvl <= lv;
        apb(OFS_CTRL, 1'b1, 32'h2, r, e);
        wait_idle(r);
        chk({31'h0, r[STAT_CALL_BIT]}, 32'h1, "first byte ok");
        chk({31'h0, r[STAT_INT_BIT]}, {31'h0, j != 0}, "int pin");
        chk({24'h0, 8'(mAcks - acks0)}, wd ? 32'h2 : 32'h3, "pulse count");
        apb(OFS_RESULT, 1'b0, 32'h0, res, e);
        msk = wd ? 32'h0700_FFFF : 32'h07FF_FFFF;
        chk(res & msk, exp_res(w1, w2, wd, l) & msk, "ack bytes");
      end
      d = 8'($urandom);
      apb(OFS_OPCMD, 1'b1, {23'h0, 1'b1, d}, r, e);
      apb(OFS_CTRL, 1'b1, 32'h4, r, e);
      wait_idle(r);
      chk({24'h0, mOpWord}, {24'h0, d}, "command word");
      $display("test config %0d done", i);
    end
    give_verdict();
  end
endmodule // tb
`default_nettype wire
